// File: plm_regs.vh
// Purpose: Register indices, fields, reset values and timing counts for the part life monitor
// Assumes: Plain register port, word per register, index addresses
// Notes: Included by plm_monitor.v
`ifndef PLM_REGS_VH
`define PLM_REGS_VH
`define PLM_A_STATUS 4'h0
`define PLM_A_INRUSH 4'h1
`define PLM_A_CTLCAP 4'h2
`define PLM_A_MAINCAP 4'h3
`define PLM_A_MEAS 4'h4
`define PLM_A_HOURS 4'h5
`define PLM_A_THRESH 4'h6
`define PLM_A_OUTSEL 4'h7
`define PLM_A_CAPVAL 4'h8
`define PLM_A_MARKS 4'h9
`define PLM_BIT_CTL 0
`define PLM_BIT_MAIN 1
`define PLM_BIT_FAN 2
`define PLM_BIT_INRUSH 3
`define PLM_MEAS_IDLE 4'h0
`define PLM_MEAS_START 4'h1
`define PLM_MEAS_BUSY 4'h2
`define PLM_MEAS_DONE 4'h3
`define PLM_MEAS_FORCED 4'h8
`define PLM_MEAS_ERROR 4'h9
`define PLM_FULL_PCT 8'h64
`define PLM_ALARM_PCT 8'h0a
`define PLM_MAIN_ALARM_PCT 8'h55
`define PLM_CLOSE_STEP 14'h2710
`define PLM_FAN_HALF_PCT 8'h32
`define PLM_HOURS_MAX 16'h270e
`define PLM_THRESH_OFF 16'h270f
`define PLM_HUNDRED 7'h64
`define PLM_FN_LIFE_POS 8'h5a
`define PLM_FN_LIFE_NEG 8'hbe
`define PLM_FN_MAINT_POS 8'h5f
`define PLM_FN_MAINT_NEG 8'hc3
`define PLM_CLK_HZ 40000000
`define PLM_DC_TIME_MS 1000
`define PLM_HOUR_S 3600
`endif

// File: plm_monitor.v
// Purpose: Part life and maintenance monitor of a drive
// Assumes: Inputs synchronous to core_clk; power-down/up flags come from supply supervisor
// Notes: Control capacitor ageing supplied as tick events from a thermal model outside
// Overview of operation
// - Count inrush closures, drop inrush life one percent per ten thousand.
// - Inrush life at ten percent sets status bit 3 and life alarm.
// - Control capacitor life counts down from full with powered time and temperature.
// - Control capacitor life below ten percent sets status bit 0 and alarm.
// - Main capacitor life is percent of shipment, updated only after completed measurement.
// - Main capacitor life at or below 85 percent sets bit 1 and alarm.
// - Measure field codes 0,1,2,3,8,9; codes 2,3,8,9 are not writable.
// - After start written, measurement begins at next supply removal.
// - Armed power-down measurement drives DC onto motor for one second.
// - Power back before panel dark may leave busy code; restart by writing start.
// - Running motor, shutoff or start command end with 8; drive fault ends with 9.
// - Fan at half speed or lower shows warning, sets bit 2 and alarm.
// - With several fans any single slow fan raises the warning.
// - Powered time saved to nonvolatile store hourly, shown in hundred-hour units.
// - Hour count saturates at 9998 units.
// - Hour count reaching threshold asserts maintenance alarm; 9999 disables it.
// - Only whole powered hours are counted; a partial hour is kept while power is off.
// - Output code 95 routes maintenance alarm positive, 195 negative.
// - Life alarm asserts whenever any of four parts reached alarm level.
// - Output code 90 routes life alarm positive, 190 negative.
`timescale 1ns/1ps
`include "plm_regs.vh"
module plm_monitor #(
  parameter [31:0] DC_CYCLES = (`PLM_CLK_HZ / 1000) * `PLM_DC_TIME_MS,
  // One hour of core_clk does not fit in 32 bits; the 40-bit operand widens the product
  parameter [39:0] HOUR_CYCLES = 40'd1 * `PLM_CLK_HZ * `PLM_HOUR_S,
  parameter NFAN = 2
) (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire inrush_close,
  input wire ctlcap_age_tick,
  input wire [NFAN*8-1:0] fan_speed_pct,
  input wire power_off,
  input wire main_power_good,
  input wire motor_running,
  input wire output_shutoff_input,
  input wire start_cmd,
  input wire drive_fault,
  input wire aux_supply_only_indication,
  input wire [7:0] cap_ratio_pct,
  input wire cap_ratio_valid,
  input wire [15:0] nv_hours_in,
  input wire nv_hours_load,
  output reg dc_inject,
  output reg life_alarm_out,
  output reg maint_alarm_out,
  output reg fan_warning_indication,
  output reg maint_due_indication,
  output reg general_output_terminal,
  output reg nv_save,
  output reg [15:0] nv_hours_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ARMED = 3'b010;
  localparam ST_DC = 3'b100;

  reg [7:0] inrush_pct_q;
  reg [13:0] close_cnt_q;
  reg [7:0] ctl_pct_q;
  reg [7:0] main_pct_q;
  reg [3:0] meas_q;
  reg [2:0] st_q;
  reg [31:0] dc_cnt_q;
  reg [39:0] hour_cnt_q;
  reg [6:0] hour_sub_q;
  reg [15:0] hours_q;
  reg [15:0] thresh_q;
  reg [7:0] outsel_q;
  reg [7:0] cap_hold_q;
  reg [NFAN-1:0] fan_slow;
  wire fan_any;
  wire [3:0] status;
  wire life_any;
  wire maint_hit;
  wire hour_tick;
  reg out_d;

  genvar gi;
  generate
    for (gi = 0; gi < NFAN; gi = gi + 1) begin : g_fan
      always @* begin
        fan_slow[gi] = fan_speed_pct[gi*8 +: 8] <= `PLM_FAN_HALF_PCT;
      end
    end
  endgenerate
  assign fan_any = |fan_slow;

  // Combinational so bits track each life value update directly
  assign status[`PLM_BIT_CTL] = ctl_pct_q < `PLM_ALARM_PCT;
  assign status[`PLM_BIT_MAIN] = main_pct_q <= `PLM_MAIN_ALARM_PCT;
  assign status[`PLM_BIT_FAN] = fan_any;
  assign status[`PLM_BIT_INRUSH] = inrush_pct_q <= `PLM_ALARM_PCT;
  assign life_any = |status;
  assign maint_hit = (thresh_q != `PLM_THRESH_OFF) && (hours_q >= thresh_q);
  assign hour_tick = hour_cnt_q == HOUR_CYCLES - 40'h1;

  wire wr_hours_zero = reg_wr && reg_addr == `PLM_A_HOURS && reg_wdata == 16'h0;

  always @* begin
    if (outsel_q == `PLM_FN_LIFE_POS) begin
      out_d = life_any;
    end else if (outsel_q == `PLM_FN_LIFE_NEG) begin
      out_d = ~life_any;
    end else if (outsel_q == `PLM_FN_MAINT_POS) begin
      out_d = maint_hit;
    end else if (outsel_q == `PLM_FN_MAINT_NEG) begin
      out_d = ~maint_hit;
    end else begin
      out_d = 1'b0;
    end
  end

  // Inrush wear and control capacitor ageing
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inrush_pct_q <= `PLM_FULL_PCT;
      close_cnt_q <= 14'h0;
      ctl_pct_q <= `PLM_FULL_PCT;
    end else begin
      if (inrush_close) begin
        if (close_cnt_q == `PLM_CLOSE_STEP - 14'h1) begin
          close_cnt_q <= 14'h0;
          if (inrush_pct_q != 8'h0) begin
            inrush_pct_q <= inrush_pct_q - 8'h1;
          end
        end else begin
          close_cnt_q <= close_cnt_q + 14'h1;
        end
      end
      // Ticks only count while powered
      if (ctlcap_age_tick && main_power_good && ctl_pct_q != 8'h0) begin
        ctl_pct_q <= ctl_pct_q - 8'h1;
      end
    end
  end

  // Main capacitor measurement sequence
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      meas_q <= `PLM_MEAS_IDLE;
      dc_cnt_q <= 32'h0;
      dc_inject <= 1'b0;
      main_pct_q <= `PLM_FULL_PCT;
      cap_hold_q <= 8'h0;
    end else begin
      if (cap_ratio_valid) begin
        cap_hold_q <= (cap_ratio_pct > `PLM_FULL_PCT) ? `PLM_FULL_PCT : cap_ratio_pct;
      end
      case (st_q)
        ST_IDLE: begin
          dc_inject <= 1'b0;
          // Only 0 and 1 are writable
          if (reg_wr && reg_addr == `PLM_A_MEAS && reg_wdata[3:0] <= `PLM_MEAS_START) begin
            meas_q <= reg_wdata[3:0];
            if (reg_wdata[3:0] == `PLM_MEAS_START) begin
              st_q <= ST_ARMED;
            end
          end
        end
        ST_ARMED: begin
          if (reg_wr && reg_addr == `PLM_A_MEAS && reg_wdata[3:0] == `PLM_MEAS_IDLE) begin
            meas_q <= `PLM_MEAS_IDLE;
            st_q <= ST_IDLE;
          end else if (power_off) begin
            // Disturbed start conditions leave the start code standing
            if (motor_running || output_shutoff_input || aux_supply_only_indication) begin
              st_q <= ST_IDLE;
            end else begin
              meas_q <= `PLM_MEAS_BUSY;
              st_q <= ST_DC;
              dc_cnt_q <= 32'h0;
              dc_inject <= 1'b1;
            end
          end
        end
        ST_DC: begin
          dc_cnt_q <= dc_cnt_q + 32'h1;
          if (start_cmd || motor_running || output_shutoff_input) begin
            dc_inject <= 1'b0;
            meas_q <= `PLM_MEAS_FORCED;
            st_q <= ST_IDLE;
          end else if (main_power_good || drive_fault) begin
            // Early power return aborts with busy code kept; restart needed
            dc_inject <= 1'b0;
            if (drive_fault) begin
              meas_q <= `PLM_MEAS_ERROR;
            end
            st_q <= ST_IDLE;
          end else if (dc_cnt_q == DC_CYCLES - 32'h1) begin
            dc_inject <= 1'b0;
            meas_q <= `PLM_MEAS_DONE;
            main_pct_q <= cap_hold_q;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Powered hours; partial hours never reach the unit count
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hour_cnt_q <= 40'h0;
      hour_sub_q <= 7'h0;
      hours_q <= 16'h0;
      thresh_q <= `PLM_THRESH_OFF;
      outsel_q <= 8'h0;
      nv_save <= 1'b0;
      nv_hours_out <= 16'h0;
    end else begin
      nv_save <= 1'b0;
      if (reg_wr && reg_addr == `PLM_A_THRESH && reg_wdata <= `PLM_THRESH_OFF) begin
        thresh_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `PLM_A_OUTSEL) begin
        outsel_q <= reg_wdata[7:0];
      end
      if (nv_hours_load) begin
        hours_q <= (nv_hours_in > `PLM_HOURS_MAX) ? `PLM_HOURS_MAX : nv_hours_in;
        hour_sub_q <= 7'h0;
        hour_cnt_q <= 40'h0;
      end else if (wr_hours_zero && hours_q != 16'h0) begin
        hours_q <= 16'h0;
        hour_sub_q <= 7'h0;
        hour_cnt_q <= 40'h0;
      end else if (main_power_good) begin
        if (hour_tick) begin
          hour_cnt_q <= 40'h0;
          nv_save <= 1'b1;
          if (hour_sub_q == `PLM_HUNDRED - 7'h1) begin
            hour_sub_q <= 7'h0;
            if (hours_q < `PLM_HOURS_MAX) begin
              hours_q <= hours_q + 16'h1;
              nv_hours_out <= hours_q + 16'h1;
            end else begin
              nv_hours_out <= hours_q;
            end
          end else begin
            hour_sub_q <= hour_sub_q + 7'h1;
            nv_hours_out <= hours_q;
          end
        end else begin
          hour_cnt_q <= hour_cnt_q + 40'h1;
        end
      end
    end
  end

  // Registered outputs and read port
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      life_alarm_out <= 1'b0;
      maint_alarm_out <= 1'b0;
      fan_warning_indication <= 1'b0;
      maint_due_indication <= 1'b0;
      general_output_terminal <= 1'b0;
      reg_rdata <= 16'h0;
    end else begin
      life_alarm_out <= life_any;
      maint_alarm_out <= maint_hit;
      fan_warning_indication <= fan_any;
      maint_due_indication <= maint_hit;
      general_output_terminal <= out_d;
      reg_rdata <= 16'h0;
      if (reg_rd) begin
        if (reg_addr == `PLM_A_STATUS) begin
          reg_rdata <= {12'h0, status};
        end else if (reg_addr == `PLM_A_INRUSH) begin
          reg_rdata <= {8'h0, inrush_pct_q};
        end else if (reg_addr == `PLM_A_CTLCAP) begin
          reg_rdata <= {8'h0, ctl_pct_q};
        end else if (reg_addr == `PLM_A_MAINCAP) begin
          reg_rdata <= {8'h0, main_pct_q};
        end else if (reg_addr == `PLM_A_MEAS) begin
          reg_rdata <= {12'h0, meas_q};
        end else if (reg_addr == `PLM_A_HOURS) begin
          reg_rdata <= hours_q;
        end else if (reg_addr == `PLM_A_THRESH) begin
          reg_rdata <= thresh_q;
        end else if (reg_addr == `PLM_A_OUTSEL) begin
          reg_rdata <= {8'h0, outsel_q};
        end else if (reg_addr == `PLM_A_CAPVAL) begin
          reg_rdata <= {8'h0, cap_hold_q};
        end else if (reg_addr == `PLM_A_MARKS) begin
          reg_rdata <= {13'h0, st_q};
        end
      end
    end
  end
endmodule // plm_monitor

// File: plm_monitor_asserts.sv
// Purpose: Port-level checks of the part life monitor
// Assumes: Two cooling fans, one clock domain
// Notes: Bound to every plm_monitor instance
`timescale 1ns/1ps
module plm_monitor_chk #(
  parameter [31:0] DC_CYCLES = 32'd20,
  parameter NFAN = 2
) (
  input wire core_clk,
  input wire rst_n,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [NFAN*8-1:0] fan_speed_pct,
  input wire power_off,
  input wire main_power_good,
  input wire motor_running,
  input wire output_shutoff_input,
  input wire start_cmd,
  input wire drive_fault,
  input wire dc_inject,
  input wire life_alarm_out,
  input wire fan_warning_indication,
  input wire nv_save
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] dc_cnt_q;
  wire slow = (fan_speed_pct[7:0] <= 8'h32) || (fan_speed_pct[15:8] <= 8'h32);
  wire calm = !main_power_good && !start_cmd && !motor_running && !output_shutoff_input && !drive_fault;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) dc_cnt_q <= 32'h0;
    else dc_cnt_q <= dc_inject ? dc_cnt_q + 32'h1 : 32'h0;
  end
  property p_dc_start; $rose(dc_inject) |-> $past(power_off); endproperty
  a_dc_start: assert property (p_dc_start) else $error("dc began without power off");
  property p_dc_len; $fell(dc_inject) && $past(calm) |-> dc_cnt_q == DC_CYCLES; endproperty
  a_dc_len: assert property (p_dc_len) else $error("dc length wrong");
  property p_dc_abort; dc_inject && (start_cmd || main_power_good) |=> !dc_inject; endproperty
  a_dc_abort: assert property (p_dc_abort) else $error("dc not stopped");
  property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_fan_set; slow |=> fan_warning_indication; endproperty
  a_fan_set: assert property (p_fan_set) else $error("slow fan not flagged");
  property p_fan_clr; !slow |=> !fan_warning_indication; endproperty
  a_fan_clr: assert property (p_fan_clr) else $error("fan flag stuck");
  property p_fan_alarm; fan_warning_indication |-> life_alarm_out; endproperty
  a_fan_alarm: assert property (p_fan_alarm) else $error("fan without life alarm");
  property p_nv_pulse; nv_save |=> !nv_save; endproperty
  a_nv_pulse: assert property (p_nv_pulse) else $error("save pulse too long");
  c_dc_done: cover property ($fell(dc_inject) && $past(calm));
  c_fan: cover property (fan_warning_indication);
  c_save: cover property (nv_save);
endmodule // plm_monitor_chk
bind plm_monitor plm_monitor_chk #(.DC_CYCLES(DC_CYCLES), .NFAN(NFAN)) u_chk (.core_clk, .rst_n, .reg_rd,
  .reg_rdata, .fan_speed_pct, .power_off, .main_power_good, .motor_running, .output_shutoff_input, .start_cmd,
  .drive_fault, .dc_inject, .life_alarm_out, .fan_warning_indication, .nv_save);

// File: plm_supply_model.sv
// Purpose: Supply and motor side seen during capacitor measurement
// Assumes: Motor wired and at rest
// Notes: DLY sets how slowly the capacity reading arrives
`timescale 1ns/1ps
module plm_supply_model #(
  parameter int DLY = 3
) (
  input wire core_clk,
  input wire dc_inject,
  input wire [7:0] ratio,
  output logic [7:0] cap_ratio_pct,
  output logic cap_ratio_valid,
  output logic motor_running
);
  int cnt = 0;
  assign motor_running = 1'b0;
  initial cap_ratio_pct = 8'h00;
  initial cap_ratio_valid = 1'b0;
  always @(posedge core_clk) begin
    cnt <= dc_inject ? cnt + 1 : 0;
    cap_ratio_valid <= dc_inject && cnt == DLY;
    // Stale reading toggles so a late capture cannot pass
    cap_ratio_pct <= (dc_inject && cnt == DLY) ? ratio : ~cap_ratio_pct;
  end
endmodule // plm_supply_model

// File: tb_part_life_and_maintenance_monitor.sv
// Purpose: Scenario bench of the part life monitor
// Assumes: Short DC and hour counts
// Notes: One unit of hours is 500 cycles here
`timescale 1ns/1ps
`include "plm_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_part_life_and_maintenance_monitor;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, inrush_close = 0, ctlcap_age_tick = 0, nv_hours_load = 0;
  logic power_off = 0, main_power_good = 1, start_cmd = 0, cap_ratio_valid, motor_running, dc_inject, nv_save;
  logic life_alarm_out, maint_alarm_out, fan_warning_indication, general_output_terminal;
  logic drive_fault = 0, maint_due_indication;
  logic [15:0] nv_hours_out;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, fan_speed_pct = 16'h6464, nv_hours_in = 16'h0;
  logic [7:0] ratio = 8'h50, cap_ratio_pct;
  int num_errors = 0, compares = 0;
  initial forever #12.5 core_clk = ~core_clk;
  plm_monitor #(.DC_CYCLES(32'd20), .HOUR_CYCLES(40'd5), .NFAN(2)) dut (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .inrush_close, .ctlcap_age_tick, .fan_speed_pct, .power_off, .main_power_good,
    .motor_running, .output_shutoff_input(1'b0), .start_cmd, .drive_fault, .aux_supply_only_indication(1'b0),
    .cap_ratio_pct, .cap_ratio_valid, .nv_hours_in, .nv_hours_load, .dc_inject, .life_alarm_out, .maint_alarm_out,
    .fan_warning_indication, .maint_due_indication, .general_output_terminal, .nv_save, .nv_hours_out);
  plm_supply_model #(.DLY(3)) u_supply (.core_clk, .dc_inject, .ratio, .cap_ratio_pct, .cap_ratio_valid,
    .motor_running);
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic pulses(input bit ins, input int n);
    repeat (n) begin
      @(posedge core_clk);
      if (ins) inrush_close <= 1'b1; else ctlcap_age_tick <= 1'b1;
      @(posedge core_clk);
      inrush_close <= 1'b0;
      ctlcap_age_tick <= 1'b0;
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset;
    rd(`PLM_A_STATUS, 16'h0);
    rd(`PLM_A_INRUSH, 16'h64);
    rd(`PLM_A_CTLCAP, 16'h64);
    rd(`PLM_A_MAINCAP, 16'h64);
    rd(`PLM_A_MEAS, 16'h0);
    rd(`PLM_A_THRESH, 16'h270f);
    rd(4'hf, 16'h0);
    pulses(1'b1, 10000);
    rd(`PLM_A_INRUSH, 16'h63);
    $display("reset and inrush done");
  endtask
  task automatic t_ctlcap;
    logic [7:0] code [4] = '{8'h5a, 8'hbe, 8'h5f, 8'hc3};
    logic expv [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    pulses(1'b0, 90);
    rd(`PLM_A_CTLCAP, 16'h0a);
    rd(`PLM_A_STATUS, 16'h0);
    pulses(1'b0, 1);
    rd(`PLM_A_STATUS, 16'h1);
    `CHK(life_alarm_out, 1'b1)
    for (int i = 0; i < 4; i++) begin
      wr(`PLM_A_OUTSEL, {8'h0, code[i]});
      settle;
      `CHK(general_output_terminal, expv[i])
    end
    $display("ctlcap and outsel done");
  endtask
  task automatic t_fan;
    @(posedge core_clk);
    fan_speed_pct <= 16'h3264;
    settle;
    rd(`PLM_A_STATUS, 16'h5);
    @(posedge core_clk);
    fan_speed_pct <= 16'h6432;
    settle;
    `CHK(fan_warning_indication, 1'b1)
    @(posedge core_clk);
    fan_speed_pct <= 16'h6464;
    settle;
    rd(`PLM_A_STATUS, 16'h1);
    $display("fan done");
  endtask
  task automatic power_down;
    @(posedge core_clk);
    main_power_good <= 1'b0;
    power_off <= 1'b1;
    @(posedge core_clk);
    power_off <= 1'b0;
    #1 `CHK(dc_inject, 1'b1)
  endtask
  task automatic t_meas;
    wr(`PLM_A_MEAS, 16'h2);
    rd(`PLM_A_MEAS, 16'h0);
    wr(`PLM_A_MEAS, 16'h1);
    rd(`PLM_A_MEAS, 16'h1);
    power_down;
    repeat (25) @(posedge core_clk);
    main_power_good <= 1'b1;
    rd(`PLM_A_MEAS, 16'h3);
    rd(`PLM_A_MAINCAP, 16'h50);
    rd(`PLM_A_STATUS, 16'h3);
    ratio <= 8'h46;
    wr(`PLM_A_MEAS, 16'h1);
    power_down;
    @(posedge core_clk);
    start_cmd <= 1'b1;
    @(posedge core_clk);
    start_cmd <= 1'b0;
    repeat (25) @(posedge core_clk);
    main_power_good <= 1'b1;
    rd(`PLM_A_MEAS, 16'h8);
    rd(`PLM_A_MAINCAP, 16'h50);
    // Power back mid-measurement keeps the busy code until restarted
    wr(`PLM_A_MEAS, 16'h1);
    power_down;
    repeat (5) @(posedge core_clk);
    main_power_good <= 1'b1;
    rd(`PLM_A_MEAS, 16'h2);
    wr(`PLM_A_MEAS, 16'h1);
    rd(`PLM_A_MEAS, 16'h1);
    power_down;
    @(posedge core_clk);
    drive_fault <= 1'b1;
    @(posedge core_clk);
    drive_fault <= 1'b0;
    repeat (25) @(posedge core_clk);
    main_power_good <= 1'b1;
    rd(`PLM_A_MEAS, 16'h9);
    rd(`PLM_A_MAINCAP, 16'h50);
    $display("measure done");
  endtask
  task automatic t_hours;
    wr(`PLM_A_HOURS, 16'h0);
    rd(`PLM_A_HOURS, 16'h0);
    wr(`PLM_A_THRESH, 16'h1);
    #1 `CHK(maint_alarm_out, 1'b0)
    for (int i = 0; i < 700 && maint_alarm_out !== 1'b1; i++) @(posedge core_clk);
    #1 `CHK(maint_alarm_out, 1'b1)
    if (maint_alarm_out !== 1'b1) end_of_test;
    `CHK(maint_due_indication, 1'b1)
    rd(`PLM_A_HOURS, 16'h1);
    wr(`PLM_A_THRESH, 16'h270f);
    settle;
    `CHK(maint_alarm_out, 1'b0)
    @(posedge core_clk);
    nv_hours_in <= 16'h270e;
    nv_hours_load <= 1'b1;
    @(posedge core_clk);
    nv_hours_load <= 1'b0;
    repeat (600) @(posedge core_clk);
    rd(`PLM_A_HOURS, 16'h270e);
    `CHK(nv_hours_out, 16'h270e)
    $display("hours done");
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_ctlcap;
    t_fan;
    t_meas;
    t_hours;
    end_of_test;
  end
endmodule // tb_part_life_and_maintenance_monitor
